// >>> vppsu_params.svh
// Overview of operation
// - instruction fields split from msb downward
// - minors 0x64, 0x65, 0x66 select packs, permute
// - byte pack saturates each byte to nibble
// - half pack clamps element to 8-bit max
// - second source low bytes, first source high
// - nibble permute indexed by second source nibbles
// - byte rotate left by low 3 bits
// - half rotate left by low 4 bits
// - whole register shift left, zero fill
// - byte shift left, zero fill, drop overflow
// - half shift left by low 4 bits, zero fill
// - element arithmetic right shift, sign fill
`ifndef VPPSU_PARAMS_SVH
`define VPPSU_PARAMS_SVH

`define VPPSU_MAJOR_VEC 6'h0a
`define VPPSU_MIN_PACKUS_B 8'h64
`define VPPSU_MIN_PACKUS_H 8'h65
`define VPPSU_MIN_PERM_N 8'h66
`define VPPSU_MIN_ROTL_B 8'h67
`define VPPSU_MIN_ROTL_H 8'h68
`define VPPSU_MIN_SHL_B 8'h69
`define VPPSU_MIN_SHL_H 8'h6a
`define VPPSU_MIN_SAR_B 8'h6e
`define VPPSU_MIN_SAR_H 8'h6f
`define VPPSU_MIN_SHL_W 8'h0b

`define VPPSU_MAJOR_LSB 26
`define VPPSU_DEST_LSB 21
`define VPPSU_SRCA_LSB 16
`define VPPSU_SRCB_LSB 11
`define VPPSU_RSV_LSB 8
`define VPPSU_MINOR_LSB 0

`define VPPSU_NIB_MAX 8'h0f
`define VPPSU_BYTE_MAX 16'h00ff

`define VPPSU_RST_DATA 64'h0000_0000_0000_0000
`define VPPSU_RST_DEST 5'h00

`endif

// >>> vppsu_pkg.sv
package vppsu_pkg;

    typedef enum logic [3:0] {
        VPPSU_OP_NONE = 4'h0,
        VPPSU_OP_PACKUS_B = 4'h1,
        VPPSU_OP_PACKUS_H = 4'h2,
        VPPSU_OP_PERM_N = 4'h3,
        VPPSU_OP_ROTL_B = 4'h4,
        VPPSU_OP_ROTL_H = 4'h5,
        VPPSU_OP_SHL_W = 4'h6,
        VPPSU_OP_SHL_B = 4'h7,
        VPPSU_OP_SHL_H = 4'h8,
        VPPSU_OP_SAR_B = 4'h9,
        VPPSU_OP_SAR_H = 4'ha
    } vppsu_op_t;

    // field order matches the instruction word, msb first
    typedef struct packed {
        logic [5:0] major;
        logic [4:0] dest;
        logic [4:0] src_a;
        logic [4:0] src_b;
        logic [2:0] rsv;
        logic [7:0] minor;
    } vppsu_instr_t;

endpackage

// >>> vppsu_op_if.sv
`timescale 1ns/100ps
`default_nettype none

interface vppsu_op_if;
    import vppsu_pkg::*;
    vppsu_op_t op;
    logic [63:0] a;
    logic [63:0] b;
    logic [63:0] res;

    modport drv (output op, output a, output b, input res);
    modport alu (input op, input a, input b, output res);
endinterface

`default_nettype wire

// >>> vppsu_alu.sv
`timescale 1ns/100ps
`default_nettype none
`include "vppsu_params.svh"

module vppsu_alu
    import vppsu_pkg::*;
(
    vppsu_op_if.alu opif
);

    function automatic logic [3:0] clamp_to_unsigned_nibble(input logic [7:0] x);
        return (x > `VPPSU_NIB_MAX) ? 4'hf : x[3:0];
    endfunction

    function automatic logic [7:0] clamp_to_unsigned_byte(input logic [15:0] x);
        return (x > `VPPSU_BYTE_MAX) ? 8'hff : x[7:0];
    endfunction

    function automatic logic [7:0] rotl8(input logic [7:0] e, input logic [2:0] s);
        logic [15:0] t;
        t = {e, e} << s;
        return t[15:8];
    endfunction

    function automatic logic [15:0] rotl16(input logic [15:0] e, input logic [3:0] s);
        logic [31:0] t;
        t = {e, e} << s;
        return t[31:16];
    endfunction

    always_comb begin
        opif.res = '0;
        case (opif.op)
            VPPSU_OP_PACKUS_B: begin
                for (int i = 0; i < 8; i++) begin
                    opif.res[i*4 +: 4] = clamp_to_unsigned_nibble(opif.b[i*8 +: 8]);
                    opif.res[32 + i*4 +: 4] = clamp_to_unsigned_nibble(opif.a[i*8 +: 8]);
                end
            end
            VPPSU_OP_PACKUS_H: begin
                for (int i = 0; i < 4; i++) begin
                    opif.res[i*8 +: 8] = clamp_to_unsigned_byte(opif.b[i*16 +: 16]);
                    opif.res[32 + i*8 +: 8] = clamp_to_unsigned_byte(opif.a[i*16 +: 16]);
                end
            end
            VPPSU_OP_PERM_N: begin
                for (int i = 0; i < 16; i++) begin
                    opif.res[i*4 +: 4] = opif.a[{opif.b[i*4 +: 4], 2'b00} +: 4];
                end
            end
            VPPSU_OP_ROTL_B: begin
                for (int i = 0; i < 8; i++) begin
                    opif.res[i*8 +: 8] = rotl8(opif.a[i*8 +: 8], opif.b[i*8 +: 3]);
                end
            end
            VPPSU_OP_ROTL_H: begin
                for (int i = 0; i < 4; i++) begin
                    opif.res[i*16 +: 16] = rotl16(opif.a[i*16 +: 16], opif.b[i*16 +: 4]);
                end
            end
            VPPSU_OP_SHL_W: begin
                opif.res = opif.a << opif.b[2:0];
            end
            VPPSU_OP_SHL_B: begin
                for (int i = 0; i < 8; i++) begin
                    opif.res[i*8 +: 8] = opif.a[i*8 +: 8] << opif.b[i*8 +: 3];
                end
            end
            VPPSU_OP_SHL_H: begin
                for (int i = 0; i < 4; i++) begin
                    opif.res[i*16 +: 16] = opif.a[i*16 +: 16] << opif.b[i*16 +: 4];
                end
            end
            VPPSU_OP_SAR_B: begin
                for (int i = 0; i < 8; i++) begin
                    opif.res[i*8 +: 8] = 8'($signed(opif.a[i*8 +: 8]) >>> opif.b[i*8 +: 3]);
                end
            end
            VPPSU_OP_SAR_H: begin
                for (int i = 0; i < 4; i++) begin
                    opif.res[i*16 +: 16] = 16'($signed(opif.a[i*16 +: 16]) >>> opif.b[i*16 +: 4]);
                end
            end
            default: begin
                opif.res = '0;
            end
        endcase
    end

endmodule

`default_nettype wire

// >>> vppsu_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "vppsu_params.svh"

module vppsu_top
    import vppsu_pkg::*;
#(
    parameter bit IS_64BIT = 1'b1
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic issue_valid,
    input wire logic [31:0] instr,
    input wire logic [63:0] first_source_reg,
    input wire logic [63:0] second_source_reg,
    output logic wr_valid_q,
    output logic [4:0] wr_dest_q,
    output logic [63:0] wr_data_q,
    output logic unsupported_q
);

    vppsu_op_if opif ();

    vppsu_instr_t instr_s;
    vppsu_op_t op_dec;
    logic supported;
    logic wr_valid_d;
    logic [4:0] wr_dest_d;
    logic [63:0] wr_data_d;
    logic unsupported_d;

    function automatic vppsu_op_t decode_minor(input logic [7:0] minor);
        case (minor)
            `VPPSU_MIN_PACKUS_B: return VPPSU_OP_PACKUS_B;
            `VPPSU_MIN_PACKUS_H: return VPPSU_OP_PACKUS_H;
            `VPPSU_MIN_PERM_N: return VPPSU_OP_PERM_N;
            `VPPSU_MIN_ROTL_B: return VPPSU_OP_ROTL_B;
            `VPPSU_MIN_ROTL_H: return VPPSU_OP_ROTL_H;
            `VPPSU_MIN_SHL_B: return VPPSU_OP_SHL_B;
            `VPPSU_MIN_SHL_H: return VPPSU_OP_SHL_H;
            `VPPSU_MIN_SAR_B: return VPPSU_OP_SAR_B;
            `VPPSU_MIN_SAR_H: return VPPSU_OP_SAR_H;
            `VPPSU_MIN_SHL_W: return VPPSU_OP_SHL_W;
            default: return VPPSU_OP_NONE;
        endcase
    endfunction

    // reserved bits are ignored, not checked, so odd encodings still run
    always_comb begin
        instr_s = vppsu_instr_t'(instr);
        op_dec = VPPSU_OP_NONE;
        if (IS_64BIT && instr_s.major == `VPPSU_MAJOR_VEC) begin
            op_dec = decode_minor(instr_s.minor);
        end
        supported = (op_dec != VPPSU_OP_NONE);
    end

    assign opif.op = op_dec;
    assign opif.a = first_source_reg;
    assign opif.b = second_source_reg;

    vppsu_alu u_alu (
        .opif(opif.alu)
    );

    // unsupported is a plain flag to the pipeline; nothing traps here
    always_comb begin
        wr_valid_d = issue_valid && supported;
        unsupported_d = issue_valid && !supported;
        wr_dest_d = issue_valid ? instr_s.dest : `VPPSU_RST_DEST;
        wr_data_d = (issue_valid && supported) ? opif.res : `VPPSU_RST_DATA;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_valid_q <= 1'b0;
            wr_dest_q <= `VPPSU_RST_DEST;
            wr_data_q <= `VPPSU_RST_DATA;
            unsupported_q <= 1'b0;
        end else begin
            wr_valid_q <= wr_valid_d;
            wr_dest_q <= wr_dest_d;
            wr_data_q <= wr_data_d;
            unsupported_q <= unsupported_d;
        end
    end

    field_split_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        issue_valid |=> wr_dest_q == $past(instr[25:21]))
        else $error("destination field not taken from bits 25:21");

    write_only_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (issue_valid && supported) |=> wr_valid_q && !unsupported_q)
        else $error("supported op did not write destination");

    unsup_enc_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (issue_valid && (!IS_64BIT || instr[31:26] != `VPPSU_MAJOR_VEC)) |=> unsupported_q && !wr_valid_q)
        else $error("foreign or 32-bit encoding not flagged");

    pack_byte_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (issue_valid && op_dec == VPPSU_OP_PACKUS_B) |=>
        wr_data_q[63:60] == (($past(first_source_reg[63:56]) > 8'h0f) ? 4'hf : $past(first_source_reg[59:56]))
        && wr_data_q[59:56] == (($past(first_source_reg[55:48]) > 8'h0f) ? 4'hf : $past(first_source_reg[51:48])))
        else $error("byte pack top nibbles wrong");

    pack_half_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (issue_valid && op_dec == VPPSU_OP_PACKUS_H) |=>
        wr_data_q[7:0] == (($past(second_source_reg[15:0]) > 16'h00ff) ? 8'hff : $past(second_source_reg[7:0]))
        && wr_data_q[39:32] == (($past(first_source_reg[15:0]) > 16'h00ff) ? 8'hff : $past(first_source_reg[7:0])))
        else $error("half pack placement or clamp wrong");

    perm_nib_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (issue_valid && op_dec == VPPSU_OP_PERM_N) |=>
        wr_data_q[63:60] == 4'($past(first_source_reg) >> {$past(second_source_reg[63:60]), 2'b00}))
        else $error("nibble permute picked wrong nibble");

    rot_byte_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (issue_valid && op_dec == VPPSU_OP_ROTL_B) |=>
        wr_data_q[15:8] == 8'(($past(first_source_reg[15:8]) << $past(second_source_reg[10:8]))
        | ($past(first_source_reg[15:8]) >> (4'h8 - {1'b0, $past(second_source_reg[10:8])}))))
        else $error("byte rotate wrong");

    rot_half_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (issue_valid && op_dec == VPPSU_OP_ROTL_H) |=>
        wr_data_q[31:16] == 16'(($past(first_source_reg[31:16]) << $past(second_source_reg[19:16]))
        | ($past(first_source_reg[31:16]) >> (5'h10 - {1'b0, $past(second_source_reg[19:16])}))))
        else $error("half rotate wrong");

    whole_shl_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (issue_valid && op_dec == VPPSU_OP_SHL_W) |=>
        wr_data_q == ($past(first_source_reg) << $past(second_source_reg[2:0])))
        else $error("whole register shift wrong");

    shl_byte_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (issue_valid && op_dec == VPPSU_OP_SHL_B && second_source_reg[58:56] == 3'h7) |=>
        wr_data_q[63:56] == {$past(first_source_reg[56]), 7'h00})
        else $error("byte shift left did not drop or zero fill");

    shl_half_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (issue_valid && op_dec == VPPSU_OP_SHL_H) |=>
        wr_data_q[15:0] == ($past(first_source_reg[15:0]) << $past(second_source_reg[3:0])))
        else $error("half shift left wrong");

    sar_sign_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (issue_valid && op_dec == VPPSU_OP_SAR_B && second_source_reg[2:0] == 3'h7) |=>
        wr_data_q[7:0] == {8{$past(first_source_reg[7])}})
        else $error("byte arithmetic shift lost sign");

    sar_half_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (issue_valid && op_dec == VPPSU_OP_SAR_H) |=>
        wr_data_q[63] == $past(first_source_reg[63]))
        else $error("half arithmetic shift lost sign");

    // a stale result left standing would be written twice by the pipeline
    idle_quiet_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !issue_valid |=> !wr_valid_q && !unsupported_q
        && wr_dest_q == `VPPSU_RST_DEST && wr_data_q == `VPPSU_RST_DATA)
        else $error("idle cycle left a result standing");

    refused_data_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (issue_valid && !supported) |=> !wr_valid_q && wr_data_q == `VPPSU_RST_DATA)
        else $error("refused encoding produced data");

    pack_low_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (issue_valid && op_dec == VPPSU_OP_PACKUS_B) |=>
        wr_data_q[3:0] == (($past(second_source_reg[7:0]) > 8'h0f) ? 4'hf : $past(second_source_reg[3:0])))
        else $error("byte pack low nibble wrong");

    pack_top_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (issue_valid && op_dec == VPPSU_OP_PACKUS_H) |=>
        wr_data_q[63:56] == (($past(first_source_reg[63:48]) > 16'h00ff) ? 8'hff : $past(first_source_reg[55:48])))
        else $error("half pack top byte wrong");

    perm_low_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (issue_valid && op_dec == VPPSU_OP_PERM_N) |=>
        wr_data_q[3:0] == 4'($past(first_source_reg) >> {$past(second_source_reg[3:0]), 2'b00}))
        else $error("nibble permute low nibble wrong");

    rot_low_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (issue_valid && op_dec == VPPSU_OP_ROTL_B) |=>
        wr_data_q[7:0] == 8'(($past(first_source_reg[7:0]) << $past(second_source_reg[2:0]))
        | ($past(first_source_reg[7:0]) >> (4'h8 - {1'b0, $past(second_source_reg[2:0])}))))
        else $error("low byte rotate wrong");

    whole_fill_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (issue_valid && op_dec == VPPSU_OP_SHL_W && second_source_reg[2:0] == 3'h7) |=>
        wr_data_q == {$past(first_source_reg[56:0]), 7'h00})
        else $error("whole shift by seven wrong");

    shl_half_top_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (issue_valid && op_dec == VPPSU_OP_SHL_H) |=>
        wr_data_q[63:48] == 16'($past(first_source_reg[63:48]) << $past(second_source_reg[51:48])))
        else $error("top half shift left wrong");

    sar_half_fill_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (issue_valid && op_dec == VPPSU_OP_SAR_H && second_source_reg[3:0] == 4'hf) |=>
        wr_data_q[15:0] == {16{$past(first_source_reg[15])}})
        else $error("half arithmetic shift by fifteen lost sign");

endmodule

`default_nettype wire

// >>> vppsu_pipe_model.sv
`timescale 1ns/100ps
`default_nettype none

module vppsu_pipe_model (
    input wire logic clk_sys,
    output logic issue_valid,
    output logic [31:0] instr,
    output logic [63:0] first_source_reg,
    output logic [63:0] second_source_reg,
    input wire logic wr_valid_q,
    input wire logic [4:0] wr_dest_q,
    input wire logic [63:0] wr_data_q
);
    logic [63:0] gpr_q [32];

    initial begin
        issue_valid = 1'b0;
        instr = 32'h0000_0000;
        first_source_reg = 64'h0;
        second_source_reg = 64'h0;
    end

    // register file write back, the only effect a result may have
    always_ff @(posedge clk_sys) begin
        if (wr_valid_q) begin
            gpr_q[wr_dest_q] <= wr_data_q;
        end
    end

    // idle cycles invert the buses so stale values cannot pass for a sample
    task automatic drive(input logic v, input logic [31:0] ins, input logic [63:0] a, input logic [63:0] b);
        issue_valid = v;
        instr = v ? ins : ~instr;
        first_source_reg = v ? a : ~first_source_reg;
        second_source_reg = v ? b : ~second_source_reg;
    endtask
endmodule

`default_nettype wire

// >>> vector_pack_permute_shift_unit_bench.sv
`timescale 1ns/100ps
`default_nettype none

module vector_pack_permute_shift_unit_bench;
    import vppsu_pkg::*;
    logic clk_sys;
    logic rst_n;
    logic issue_valid;
    logic [31:0] instr;
    logic [63:0] src_a;
    logic [63:0] src_b;
    logic wr_valid_q;
    logic [4:0] wr_dest_q;
    logic [63:0] wr_data_q;
    logic unsupported_q;
    logic narrow_valid;
    logic narrow_unsup;
    logic [63:0] narrow_data;
    int fails = 0;
    int compares = 0;

    vppsu_pipe_model pm (.clk_sys(clk_sys), .issue_valid(issue_valid), .instr(instr), .first_source_reg(src_a),
        .second_source_reg(src_b), .wr_valid_q(wr_valid_q), .wr_dest_q(wr_dest_q), .wr_data_q(wr_data_q));
    vppsu_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .issue_valid(issue_valid), .instr(instr),
        .first_source_reg(src_a), .second_source_reg(src_b), .wr_valid_q(wr_valid_q), .wr_dest_q(wr_dest_q),
        .wr_data_q(wr_data_q), .unsupported_q(unsupported_q));
    // a 32-bit build sees the very same stream
    vppsu_top #(.IS_64BIT(1'b0)) dut32 (.clk_sys(clk_sys), .rst_n(rst_n), .issue_valid(issue_valid),
        .instr(instr), .first_source_reg(src_a), .second_source_reg(src_b), .wr_valid_q(narrow_valid),
        .wr_dest_q(), .wr_data_q(narrow_data), .unsupported_q(narrow_unsup));

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    function automatic logic [63:0] ref_res(input logic [7:0] mn, input logic [63:0] a, input logic [63:0] b);
        logic [63:0] r;
        int i;
        r = 64'h0;
        for (i = 0; i < 16; i++) begin
            case (mn)
                8'h64: if (i < 8) begin
                    r[4*i+:4] = (b[8*i+:8] > 8'h0f) ? 4'hf : b[8*i+:4];
                    r[32+4*i+:4] = (a[8*i+:8] > 8'h0f) ? 4'hf : a[8*i+:4];
                end
                8'h65: if (i < 4) begin
                    r[8*i+:8] = (b[16*i+:16] > 16'h00ff) ? 8'hff : b[16*i+:8];
                    r[32+8*i+:8] = (a[16*i+:16] > 16'h00ff) ? 8'hff : a[16*i+:8];
                end
                8'h66: r[4*i+:4] = a[4*b[4*i+:4]+:4];
                8'h67: if (i < 8) r[8*i+:8] = (a[8*i+:8] << b[8*i+:3]) | (a[8*i+:8] >> (8 - b[8*i+:3]));
                8'h68: if (i < 4) r[16*i+:16] = (a[16*i+:16] << b[16*i+:4]) | (a[16*i+:16] >> (16 - b[16*i+:4]));
                8'h69: if (i < 8) r[8*i+:8] = a[8*i+:8] << b[8*i+:3];
                8'h6a: if (i < 4) r[16*i+:16] = a[16*i+:16] << b[16*i+:4];
                8'h6e: if (i < 8) r[8*i+:8] = $signed(a[8*i+:8]) >>> b[8*i+:3];
                8'h6f: if (i < 4) r[16*i+:16] = $signed(a[16*i+:16]) >>> b[16*i+:4];
                8'h0b: if (i == 0) r = a << b[2:0];
                default: r = 64'h0;
            endcase
        end
        return r;
    endfunction

    // issued at a falling edge, judged at the next one; calls chain back to back
    task automatic run(input logic [7:0] mn, input logic [5:0] mj, input logic [2:0] rsv,
        input logic [63:0] a, input logic [63:0] b, input logic ok);
        pm.drive(1'b1, {mj, mn[4:0], 5'h01, 5'h02, rsv, mn}, a, b);
        @(negedge clk_sys);
        check(64'(wr_valid_q), 64'(ok));
        check(64'(unsupported_q), 64'(!ok));
        check(64'(wr_dest_q), 64'(mn[4:0]));
        check(wr_data_q, ok ? ref_res(mn, a, b) : 64'h0);
        check(64'({narrow_valid, narrow_unsup}), 64'h1);
        check(narrow_data, 64'h0);
    endtask

    task automatic idle();
        pm.drive(1'b0, 32'h0, 64'h0, 64'h0);
        @(negedge clk_sys);
        check(wr_data_q, 64'h0);
        check(64'({wr_valid_q, unsupported_q, wr_dest_q}), 64'h0);
    endtask

    task automatic t_pack();
        run(8'h64, 6'h0a, 3'h0, 64'h0f10ff00_7f0e1001, 64'h100f08ff_0001200e, 1'b1);
        run(8'h65, 6'h0a, 3'h0, 64'h00ff0100_ffff0012, 64'h010000ff_800000fe, 1'b1);
        idle();
    endtask

    task automatic t_perm();
        run(8'h66, 6'h0a, 3'h0, 64'hfedcba98_76543210, 64'h01234567_89abcdef, 1'b1);
        run(8'h66, 6'h0a, 3'h0, 64'h0f1e2d3c_4b5a6978, 64'hffff0000_5a5a1234, 1'b1);
        idle();
    endtask

    task automatic t_rotate();
        run(8'h67, 6'h0a, 3'h0, 64'h80017f80_c3a50102, 64'h07060504_03020f08, 1'b1);
        run(8'h68, 6'h0a, 3'h0, 64'h80017f80_c3a50102, 64'h000f0008_00110001, 1'b1);
        idle();
    endtask

    task automatic t_shift();
        logic [7:0] mins [5];
        int k;
        mins = '{8'h69, 8'h6a, 8'h6e, 8'h6f, 8'h0b};
        for (k = 0; k < 5; k++) begin
            run(mins[k], 6'h0a, 3'h0, 64'h80ff7f01_c0008001, 64'h0f0f0907_03010a0f, 1'b1);
        end
        idle();
    endtask

    task automatic t_refuse();
        run(8'h64, 6'h0b, 3'h0, 64'h1, 64'h2, 1'b0);
        run(8'h6b, 6'h0a, 3'h0, 64'h1, 64'h2, 1'b0);
        run(8'h0a, 6'h0a, 3'h0, 64'h1, 64'h2, 1'b0);
        run(8'h64, 6'h0a, 3'h7, 64'h0f10ff00_7f0e1001, 64'h100f08ff_0001200e, 1'b1);
        idle();
        check(pm.gpr_q[5'h04], ref_res(8'h64, 64'h0f10ff00_7f0e1001, 64'h100f08ff_0001200e));
    endtask

    // reset dropped while a result stands must clear it at once
    task automatic t_reset();
        run(8'h65, 6'h0a, 3'h0, 64'h00ff0100_ffff0012, 64'h010000ff_800000fe, 1'b1);
        rst_n = 1'b0;
        pm.drive(1'b0, 32'h0, 64'h0, 64'h0);
        #1;
        check(wr_data_q, 64'h0);
        check(64'({wr_valid_q, unsupported_q, wr_dest_q}), 64'h0);
        @(negedge clk_sys);
        rst_n = 1'b1;
        idle();
    endtask

    initial begin
        rst_n = 1'b0;
        pm.drive(1'b0, 32'h0, 64'h0, 64'h0);
        repeat (8) @(negedge clk_sys);
        check(wr_data_q, 64'h0);
        check(64'({wr_valid_q, unsupported_q, wr_dest_q}), 64'h0);
        rst_n = 1'b1;
        t_pack();
        t_perm();
        t_rotate();
        t_shift();
        t_refuse();
        t_reset();
        close_out();
    end

    // the whole sequence needs well under a hundred cycles
    initial begin
        #(25 * 2000);
        fails++;
        close_out();
    end
endmodule

`default_nettype wire
